/* inc/aitp_pkg.sv */
/*
  Shared constants, states and carriers of the two-wire target port.
  Assumes a 10 MHz system clock and a bus master that runs SCL at or
  below the fast-mode rate.
*/
`default_nettype none

package aitp_pkg;

  // ***************************************************************
  // Bus addresses and byte layout
  // ***************************************************************
  localparam logic [6:0] TGT_ADDR_STRAP_HIGH = 7'h1d;
  localparam logic [6:0] TGT_ADDR_STRAP_LOW = 7'h53;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam int unsigned REG_AW = 8;
  localparam logic [REG_AW-1:0] PTR_RESET = 8'h00;
  localparam logic [REG_AW-1:0] PTR_STEP = 8'h01;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned SYS_CLK_KHZ = 10000;
  localparam int unsigned STD_SCL_KHZ = 100;
  localparam int unsigned FAST_SCL_KHZ = 400;
  localparam int unsigned SCL_HIGH_MIN_NS = 600;
  localparam int unsigned SYS_PERIOD_NS = 1000000 / SYS_CLK_KHZ;
  // Shortest SCL high phase in system cycles, rounded down.
  localparam int unsigned SCL_HIGH_MIN_CYC = SCL_HIGH_MIN_NS / SYS_PERIOD_NS;
  // Two synchroniser stages plus one edge-detect stage.
  localparam int unsigned EDGE_LATENCY_CYC = 3;

  // ***************************************************************
  // States and carriers
  // ***************************************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_REGA   = 6'b000100,
    ST_WR     = 6'b001000,
    ST_RD     = 6'b010000,
    ST_IGNORE = 6'b100000
  } aitp_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel;
    logic strap;
  } aitp_pins_s;

  typedef struct packed {
    logic stb;
    logic [REG_AW-1:0] addr;
    logic [7:0] data;
  } aitp_wr_s;

endpackage : aitp_pkg

`default_nettype wire

/* rtl/aitp_reg_mem.sv */
/*
  Register storage behind the target port.
  Assumes writes arrive as one-cycle strobes on the system clock; the
  bus side reads combinationally, the device core reads registered.
*/
`timescale 1ns/1ns
`default_nettype none

module aitp_reg_mem (
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire aitp_pkg::aitp_wr_s wr, // Write strobe, address, data.
  input wire logic [aitp_pkg::REG_AW-1:0] rd_addr, // Bus read pointer.
  output logic [7:0] rd_data, // Bus read data, combinational.
  input wire logic [aitp_pkg::REG_AW-1:0] core_addr, // Core read address.
  output logic [7:0] core_rdata // Core read data, registered.
);
  import aitp_pkg::*;

  localparam int unsigned DEPTH = 1 << REG_AW;

  logic [7:0] mem_r [DEPTH];
  logic [7:0] core_rdata_r;
  logic [7:0] core_rdata_nxt;

  always_comb
  begin
    rd_data = mem_r[rd_addr];
    core_rdata_nxt = mem_r[core_addr];
  end

  // The array itself carries no reset so that it maps onto plain RAM.
  always_ff @(posedge sys_clk)
  begin
    if (wr.stb)
    begin
      mem_r[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      core_rdata_r <= DATA_RESET;
    end
    else
    begin
      core_rdata_r <= core_rdata_nxt;
    end
  end

  assign core_rdata = core_rdata_r;

endmodule : aitp_reg_mem

`default_nettype wire

/* rtl/aitp_target_port.sv */
/*
  Two-wire serial target port with register pointer and storage.
  Assumes SCL comes from the bus master and clocks only the bit capture;
  all protocol decisions run on sys_clk from synchronised pin levels and the byte in the SCL-clocked capture register.
  The open-drain SDA pin is split into input, output and enable.
*/
// Overview of operation
// RULE1: The port acts as a bus target only while the select pin is high.
// RULE2: Standard and fast rate transfers work; the master stays <=400 kHz.
// RULE3: Single and multiple byte register reads and writes are accepted.
// RULE4: With the strap high the port answers address 0x1D (0x3A/0x3B).
// RULE5: With the strap low the port answers address 0x53 (0xA6/0xA7).
// RULE6: Writes are START, address+W, register, data bytes, STOP, all acked.
// RULE7: Reads write the register, restart, send address+R, which is acked.
// RULE8: The master acks every read byte but the last, then NACK and STOP.
// RULE9: The register pointer steps by one after every data byte.
`timescale 1ns/1ns
`default_nettype none

module aitp_target_port (
  input wire logic sys_clk, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic scl_clk, // Bus clock from the master.
  input wire logic sda_in, // SDA pin level.
  output logic sda_out, // SDA drive value, always low.
  output logic sda_oe, // SDA pull-down enable, high drives.
  input wire logic sel_pin, // Interface select pin.
  input wire logic target_address_strap, // Bus address strap pin.
  input wire logic [aitp_pkg::REG_AW-1:0] core_addr, // Core read address.
  output logic [7:0] core_rdata, // Core read data.
  output aitp_pkg::aitp_wr_s wr_event // Register write strobe.
);
  import aitp_pkg::*;

  // ***************************************************************
  // Bit capture on the link clock
  // ***************************************************************
  // SDA is stable around each SCL rise, so the bus clock samples it
  // directly; this register is the only state in the link domain.
  logic [7:0] rx_shift_r;
  logic [7:0] rx_shift_nxt;

  always_comb
  begin
    rx_shift_nxt = {rx_shift_r[6:0], sda_in};
  end

  always_ff @(posedge scl_clk)
  begin
    rx_shift_r <= rx_shift_nxt;
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  aitp_pins_s pins_meta_r;
  aitp_pins_s pins_sync_r;
  aitp_pins_s pins_prev_r;
  aitp_pins_s pins_meta_nxt;
  aitp_pins_s pins_sync_nxt;
  aitp_pins_s pins_prev_nxt;
  aitp_pins_s pins_idle;

  always_comb
  begin
    pins_idle = '{scl: 1'b1, sda: 1'b1, sel: 1'b0, strap: 1'b0};
    pins_meta_nxt = '{scl: scl_clk, sda: sda_in, sel: sel_pin,
                      strap: target_address_strap};
    pins_sync_nxt = pins_meta_r;
    pins_prev_nxt = pins_sync_r;
  end

  // The edge latency of three cycles stays well inside the shortest
  // SCL high phase at the fast rate, so no edge is missed.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pins_meta_r <= pins_idle;
      pins_sync_r <= pins_idle;
      pins_prev_r <= pins_idle;
    end
    else
    begin
      pins_meta_r <= pins_meta_nxt;
      pins_sync_r <= pins_sync_nxt; // RULE2
      pins_prev_r <= pins_prev_nxt;
    end
  end

  // ***************************************************************
  // Bus events
  // ***************************************************************
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;

  always_comb
  begin
    scl_rise = pins_sync_r.scl & ~pins_prev_r.scl;
    scl_fall = ~pins_sync_r.scl & pins_prev_r.scl;
    bus_start = pins_sync_r.scl & pins_prev_r.scl &
                pins_prev_r.sda & ~pins_sync_r.sda;
    bus_stop = pins_sync_r.scl & pins_prev_r.scl &
               ~pins_prev_r.sda & pins_sync_r.sda;
    if (pins_sync_r.strap)
    begin
      own_addr = TGT_ADDR_STRAP_HIGH; // RULE4
    end
    else
    begin
      own_addr = TGT_ADDR_STRAP_LOW; // RULE5
    end
  end

  // ***************************************************************
  // Protocol engine
  // ***************************************************************
  aitp_state_e state_r;
  aitp_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [REG_AW-1:0] ptr_r;
  logic [REG_AW-1:0] ptr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic ack_pend_r;
  logic ack_pend_nxt;
  logic oe_r;
  logic oe_nxt;
  logic sda_out_r;
  aitp_wr_s wr_r;
  aitp_wr_s wr_nxt;
  logic [7:0] rd_data;
  logic [7:0] rx_byte;
  logic [2:0] bit_sel;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    ack_pend_nxt = ack_pend_r;
    oe_nxt = oe_r;
    wr_nxt = wr_r;
    wr_nxt.stb = 1'b0;
    // The capture register is read only on a synchronised SCL rise:
    // it last changed three cycles ago and holds until the next rise.
    rx_byte = rx_shift_r;
    bit_sel = 3'(BIT_LAST - cnt_r);
    if (!pins_sync_r.sel)
    begin
      state_nxt = ST_IDLE; // RULE1
      cnt_nxt = BIT_FIRST;
      ack_pend_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (bus_start)
    begin
      // A repeated start behaves like a fresh one; the pointer stays.
      state_nxt = ST_ADDR; // RULE7
      cnt_nxt = BIT_FIRST;
      ack_pend_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (bus_stop)
    begin
      state_nxt = ST_IDLE; // RULE6
      cnt_nxt = BIT_FIRST;
      ack_pend_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (state_r == ST_IDLE || state_r == ST_IGNORE)
    begin
      oe_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      if (cnt_r == BIT_ACK)
      begin
        cnt_nxt = BIT_FIRST;
        if (ack_pend_r)
        begin
          ack_pend_nxt = 1'b0;
        end
        else if (state_r == ST_RD)
        begin
          if (pins_sync_r.sda)
          begin
            state_nxt = ST_IGNORE; // RULE8
          end
          else
          begin
            tx_nxt = rd_data; // RULE3
            ptr_nxt = ptr_r + PTR_STEP; // RULE9
          end
        end
      end
      else
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == BIT_LAST)
        begin
          case (state_r)
            ST_ADDR:
            begin
              if (rx_byte[7:1] == own_addr)
              begin
                ack_pend_nxt = 1'b1; // RULE4
                if (rx_byte[0])
                begin
                  state_nxt = ST_RD; // RULE7
                  tx_nxt = rd_data;
                  ptr_nxt = ptr_r + PTR_STEP; // RULE9
                end
                else
                begin
                  state_nxt = ST_REGA; // RULE6
                end
              end
              else
              begin
                state_nxt = ST_IGNORE; // RULE5
              end
            end
            ST_REGA:
            begin
              ptr_nxt = rx_byte;
              ack_pend_nxt = 1'b1; // RULE6
              state_nxt = ST_WR;
            end
            ST_WR:
            begin
              wr_nxt = '{stb: 1'b1, addr: ptr_r, data: rx_byte}; // RULE3
              ptr_nxt = ptr_r + PTR_STEP; // RULE9
              ack_pend_nxt = 1'b1; // RULE6
            end
            default:
            begin
              state_nxt = state_r;
            end
          endcase
        end
      end
    end
    else if (scl_fall)
    begin
      if (cnt_r == BIT_ACK)
      begin
        oe_nxt = ack_pend_r; // RULE6
      end
      else if (state_r == ST_RD && !ack_pend_r)
      begin
        oe_nxt = ~tx_r[bit_sel]; // RULE7
      end
      else
      begin
        oe_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= BIT_FIRST;
      ptr_r <= PTR_RESET;
      tx_r <= DATA_RESET;
      ack_pend_r <= 1'b0;
      oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      wr_r <= '{stb: 1'b0, addr: PTR_RESET, data: DATA_RESET};
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      ack_pend_r <= ack_pend_nxt;
      oe_r <= oe_nxt;
      sda_out_r <= 1'b0;
      wr_r <= wr_nxt;
    end
  end

  // ***************************************************************
  // Register storage
  // ***************************************************************
  aitp_reg_mem u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr(wr_r),
    .rd_addr(ptr_r),
    .rd_data(rd_data),
    .core_addr(core_addr),
    .core_rdata(core_rdata)
  );

  assign sda_out = sda_out_r;
  assign sda_oe = oe_r;
  assign wr_event = wr_r;

endmodule : aitp_target_port

`default_nettype wire

/* testbench/aitp_target_port_properties.sv */
/*
  Timing checks on the target port pins.
  Assumes SCL phases span many system clock cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module aitp_target_port_properties (
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic scl_clk, // Bus clock pin.
  input wire logic sda_out, // SDA drive value.
  input wire logic sda_oe, // SDA drive enable.
  input wire logic sel_pin, // Interface select.
  input wire aitp_pkg::aitp_wr_s wr_event // Register write strobe.
);
  import aitp_pkg::*;

  // ****************************************************************
  // Helper logic and properties
  // ****************************************************************
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Bytes of one fast-rate burst land within 300 cycles of each other.
  logic [7:0] last_a_r;
  logic [8:0] gap_r;
  always_ff @(posedge sys_clk)
  begin
    last_a_r <= wr_event.stb ? wr_event.addr : last_a_r;
    gap_r <= rst ? 9'h1ff : wr_event.stb ? 9'h000 :
      gap_r == 9'h1ff ? gap_r : gap_r + 9'h001;
  end

  a_oe_out_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_sel_idle: assert property (!sel_pin [*8] |-> !sda_oe)
    else $error("drive while not selected");
  a_stb_single: assert property (wr_event.stb |=> !wr_event.stb [*8])
    else $error("write strobe too long");
  a_ptr_step: assert property (wr_event.stb && gap_r < 9'h12c |->
    wr_event.addr == last_a_r + 8'h01)
    else $error("pointer did not step");
  a_wr_hold: assert property (!wr_event.stb |->
    $stable(wr_event.addr) && $stable(wr_event.data))
    else $error("write fields changed");
  a_oe_after_fall: assert property ($changed(sda_oe) |->
    !scl_clk && !$past(scl_clk, 2))
    else $error("sda drive moved outside scl low");
  a_oe_stands: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*8])
    else $error("sda drive too short");
  a_stb_in_high: assert property (wr_event.stb |-> $past(scl_clk, 2))
    else $error("write strobe outside scl high");

  c_write: cover property (wr_event.stb);
  c_drive: cover property ($rose(sda_oe));
  c_burst: cover property (wr_event.stb && gap_r < 9'h12c);

endmodule : aitp_target_port_properties

bind aitp_target_port aitp_target_port_properties i_props (
  .sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_out(sda_out),
  .sda_oe(sda_oe), .sel_pin(sel_pin), .wr_event(wr_event));

`default_nettype wire

/* testbench/aitp_master_model.sv */
/*
  Bus master model: drives SCL and pulls SDA low.
  Assumes the bench resolves SDA with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module aitp_master_model (
  output logic scl, // Bus clock, idles high.
  output logic sda_low, // High while pulling SDA low.
  input wire logic sda // Resolved SDA level.
);
  int thi = 1000;
  int tlo = 1500;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // SDA moves 300 ns after SCL falls so it never looks like a START.
  // A pin change falls on a system clock edge whenever the task starts on one, so it is made by
  // non-blocking assignment to keep the synchronisers free of races.
  task start;
    #300 sda_low <= 1'b0;
    #tlo scl <= 1'b1;
    #thi sda_low <= 1'b1;
    #thi scl <= 1'b0;
  endtask : start

  task stop;
    #300 sda_low <= 1'b1;
    #tlo scl <= 1'b1;
    #thi sda_low <= 1'b0;
    #thi;
  endtask : stop

  // Nine bits MSB first; a one releases SDA, bit 0 is the ack slot.
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      #300 sda_low <= !tx[i];
      #(tlo - 300) scl <= 1'b1;
      #thi rx[i] = sda;
      scl <= 1'b0;
    end
  endtask : xfer

endmodule : aitp_master_model

`default_nettype wire

/* testbench/accel_i2c_target_port_test.sv */
/*
  Self-checking bench for the two-wire target port.
  Assumes the master model paces SCL on its own time base.
*/
`timescale 1ns/1ns
`default_nettype none

module accel_i2c_target_port_test;
  import aitp_pkg::*;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sel_pin = 1'b0;
  logic strap = 1'b1;
  logic [7:0] core_addr = 8'h00;
  logic [7:0] core_rdata;
  logic scl, sda_low, sda_oe, sda_line;
  aitp_wr_s wr_event;
  logic [7:0] mem [256];
  logic [15:0] wq [$];
  int err_total = 0;
  int comparisons = 0;

  assign sda_line = !(sda_low || sda_oe === 1'b1);

  initial forever #50 sys_clk = !sys_clk;

  aitp_master_model i_mst (.scl(scl), .sda_low(sda_low), .sda(sda_line));

  aitp_target_port i_dut (.sys_clk(sys_clk), .rst(rst), .scl_clk(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .sel_pin(sel_pin),
    .target_address_strap(strap), .core_addr(core_addr),
    .core_rdata(core_rdata), .wr_event(wr_event));

  always @(posedge sys_clk)
    if (wr_event.stb === 1'b1) wq.push_back({wr_event.addr, wr_event.data});

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [7:0] abyte(input logic s, input logic rd);
    return {s ? 7'h1d : 7'h53, rd};
  endfunction : abyte

  task chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task send(input logic [7:0] b, input logic nack);
    logic [8:0] r;
    i_mst.xfer({b, 1'b1}, r);
    chk("ack", {15'h0, nack}, {15'h0, r[0]});
  endtask : send

  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #8000000;
    err_total++;
    $display("mismatch watchdog expected done seen timeout");
    end_of_test();
  end

  // ****************************************************************
  // Tests: fast and standard rate, both straps, wrap at 0xff
  // ****************************************************************
  initial
  begin
    logic [7:0] ptr, a;
    logic [8:0] r;
    int n;
    void'($urandom(75259));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    sel_pin <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      repeat (8) @(posedge sys_clk);
      strap <= k[0];
      i_mst.thi = k[1] ? 4000 : 1000;
      i_mst.tlo = k[1] ? 6000 : 1500;
      ptr = k == 0 ? 8'hfe : 8'($urandom);
      n = k == 0 ? 3 : 1 + $urandom % 4;
      repeat (4) @(posedge sys_clk);
      i_mst.start();
      send(abyte(k[0], 1'b0), 1'b0);
      send(ptr, 1'b0);
      for (int i = 0; i < n; i++)
      begin
        a = 8'(ptr + i);
        mem[a] = 8'($urandom);
        send(mem[a], 1'b0);
      end
      i_mst.stop();
      repeat (8) @(posedge sys_clk);
      for (int i = 0; i < n; i++)
      begin
        a = 8'(ptr + i);
        chk("write", {a, mem[a]}, wq.size() ? wq.pop_front() : 'x);
      end
      i_mst.start();
      send(abyte(k[0], 1'b0), 1'b0);
      send(ptr, 1'b0);
      if (k[0])
        i_mst.stop();
      i_mst.start();
      send(abyte(k[0], 1'b1), 1'b0);
      for (int i = 0; i < n; i++)
      begin
        a = 8'(ptr + i);
        i_mst.xfer({8'hff, i == n - 1}, r);
        chk("read", {8'h00, mem[a]}, {8'h00, r[8:1]});
      end
      i_mst.stop();
      @(posedge sys_clk);
      core_addr <= ptr;
      repeat (3) @(posedge sys_clk);
      #10;
      chk("core", {8'h00, mem[ptr]}, {8'h00, core_rdata});
      i_mst.start();
      send(abyte(!k[0], 1'b0), 1'b1);
      i_mst.stop();
      $display("test %0d done", k);
    end
    @(posedge sys_clk);
    sel_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    i_mst.start();
    send(abyte(strap, 1'b0), 1'b1);
    i_mst.stop();
    chk("stray writes", 16'h0, 16'(wq.size()));
    $display("test select done");
    end_of_test();
  end

endmodule : accel_i2c_target_port_test

`default_nettype wire
